// ---- common/tsr_pkg.sv ----
// Register map, field layout, reset values and timing of the sensor register file
package tsr_pkg;
	// Register pointer values
	localparam logic [7:0] ADDR_TEMP = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h01;
	localparam logic [7:0] ADDR_HI = 8'h02;
	localparam logic [7:0] ADDR_LO = 8'h03;
	localparam logic [7:0] ADDR_UNL = 8'h04;
	localparam logic [7:0] ADDR_SCR1 = 8'h05;
	localparam logic [7:0] ADDR_SCR2 = 8'h06;
	localparam logic [7:0] ADDR_OFS = 8'h07;
	localparam logic [7:0] ADDR_SCR3 = 8'h08;
	localparam logic [7:0] ADDR_ID = 8'h0f;

	// Configuration field positions
	localparam int CFG_HI_FLAG = 15;
	localparam int CFG_LO_FLAG = 14;
	localparam int CFG_DRDY = 13;
	localparam int CFG_BUSY = 12;
	localparam int CFG_MODE_HI = 11;
	localparam int CFG_MODE_LO = 10;
	localparam int CFG_CYCLE_HI = 9;
	localparam int CFG_CYCLE_LO = 7;
	localparam int CFG_AVERAGE_HI = 6;
	localparam int CFG_AVERAGE_LO = 5;
	localparam int CFG_THERM = 4;
	localparam int CFG_POLARITY = 3;
	localparam int CFG_DRSEL = 2;
	localparam int CFG_SRST = 1;
	// Unlock register field positions
	localparam int UNL_UNLOCK = 15;
	localparam int UNL_BUSY = 14;
	// Config bits kept in nonvolatile cells: 10:2, upper mode bit excluded
	localparam logic [15:0] CFG_NV_MASK = 16'h07fc;

	// Reset and factory values
	localparam logic [15:0] RST_CFG = 16'h0220;
	localparam logic [15:0] RST_HI = 16'h6000;
	localparam logic [15:0] RST_LO = 16'h8000;
	localparam logic [15:0] RST_OFS = 16'h0000;
	localparam logic [15:0] RST_TEMP = 16'h8000;
	localparam logic [15:0] RST_SCR = 16'h0000;

	// Nonvolatile cell indices
	localparam logic [2:0] NV_CFG = 3'h0;
	localparam logic [2:0] NV_HI = 3'h1;
	localparam logic [2:0] NV_LO = 3'h2;
	localparam logic [2:0] NV_SCR1 = 3'h3;
	localparam logic [2:0] NV_SCR2 = 3'h4;
	localparam logic [2:0] NV_OFS = 3'h5;
	localparam logic [2:0] NV_SCR3 = 3'h6;
	localparam logic [2:0] NV_NONE = 3'h7;

	// Timing
	localparam int CLK_FREQ_MHZ = 200;
	localparam int T_SRST_US = 2000;
	localparam int SRST_CYCLES = T_SRST_US * CLK_FREQ_MHZ;
	localparam int T_TICK_US = 500;
	localparam int TICK_CYCLES = T_TICK_US * CLK_FREQ_MHZ;
	localparam int RELOAD_CYCLES = 16;
	localparam int PROG_CYCLES = 64;
	// Cycle time per code, in half-millisecond ticks: 15.5 ms .. 16 s
	localparam logic [7:0][14:0] CYCLE_TICKS = {15'h7d00, 15'h3e80, 15'h1f40, 15'h7d0,
		15'h3e8, 15'h1f4, 15'hfa, 15'h1f};
	// Least cycle per averaging setting: none, 125 ms, 500 ms, 1 s
	localparam logic [3:0][14:0] AVERAGE_FLOOR_TICKS = {15'h7d0, 15'h3e8, 15'hfa, 15'h0};
endpackage : tsr_pkg

// ---- logic/tsr_regfile.sv ----
// Temperature sensor register file with link-clock access port
`timescale 1ns/100ps

// Operation
// - Config bit 4 picks thermostat mode when 1, window alert when 0.
// - Config bit 3 makes the alert output active high when 1, low when 0.
// - Config bit 2 routes data-ready to alert output, else limit flags.
// - Writing 1 to config bit 1 starts a 2 ms internal reset.
// - The soft reset trigger bit always reads back zero.
// - Config fields except upper mode bit persist; factory word is 0220.
// - Upper mode bit never persists, so start-up is shutdown or continuous.
// - Cycle codes give 15.5/125/250/500 ms then 1/4/8/16 s.
// - Averaging longer than cycle drops standby: 125 ms, 500 ms, 1 s.
// - Limits are signed 16-bit thresholds compared with the result.
// - Power-up or general-call reset reloads limits; defaults 6000h, 8000h.
// - With unlock bit 15 clear, writes touch only logic registers.
// - With unlock bit set, writes program the matching nonvolatile cell.
// - Unlock bit 14 mirrors config busy bit 12 during programming or reload.
// - Scratch word one is nonvolatile backed with lock-dependent writes.
// - Scratch words two and three behave exactly like word one.
// - Offset register is added to the result; resets to zero.
// - Offset-corrected result saturates instead of wrapping.
// - Identity word is read-only: revision in 15:12, part code in 11:0.
// - Thermostat: over flag sets above high, clears below low; under stays 0.
// - Data-ready sets on result update, clears on temperature or config read.
module tsr_regfile #(
	parameter int SRST_CYCLES = tsr_pkg::SRST_CYCLES,
	parameter int TICK_CYCLES = tsr_pkg::TICK_CYCLES,
	parameter int RELOAD_CYCLES = tsr_pkg::RELOAD_CYCLES,
	parameter int PROG_CYCLES = tsr_pkg::PROG_CYCLES,
	parameter logic [3:0] REV_CODE = 4'h0,
	// Arbitrary neutral part code
	parameter logic [11:0] PART_CODE = 12'h5a3,
	parameter logic [15:0] SCR_DEFAULT = tsr_pkg::RST_SCR
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic link_nrst,
	input wire logic link_rd,
	input wire logic link_wr,
	input wire logic [7:0] link_addr,
	input wire logic [15:0] link_wdata,
	output logic link_ready,
	output logic link_rvalid,
	output logic [15:0] link_rdata,
	input wire logic link_gcall,
	input wire logic conv_done,
	input wire logic [15:0] conv_data,
	output logic conv_start,
	output logic [1:0] averaging_count_select,
	output logic nvm_busy,
	output logic alert_out
);
	typedef enum logic [3:0] {
		PH_RELOAD = 4'b0001,
		PH_RUN = 4'b0010,
		PH_SRST = 4'b0100,
		PH_PROG = 4'b1000
	} tsr_phase_e;

	typedef struct packed {
		logic busy;
		logic req_tgl;
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
		logic ack_s1;
		logic ack_s2;
		logic ack_seen;
		logic gc_tgl;
		logic rvalid;
		logic [15:0] rdata;
	} tsr_link_s;

	typedef struct packed {
		tsr_phase_e phase;
		logic [19:0] tmr;
		logic hi_flag;
		logic lo_flag;
		logic drdy;
		logic [1:0] conversion_mode_field;
		logic [2:0] cycle_time_code;
		logic [1:0] averaging_count_select;
		logic thermostat_select;
		logic alert_output_polarity;
		logic alert_source_select;
		logic [15:0] hi_lim;
		logic [15:0] lo_lim;
		logic [15:0] offset;
		logic [15:0] temp;
		logic nvm_write_unlock;
		logic [2:0][15:0] scr;
		logic [6:0][15:0] nvm;
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic gc_s1;
		logic gc_s2;
		logic gc_seen;
		logic ack_tgl;
		logic [15:0] rdata;
		logic [16:0] tick;
		logic [14:0] cyc;
		logic conv_start;
		logic alert;
	} tsr_core_s;

	tsr_link_s l_r;
	tsr_link_s l_nxt;
	tsr_core_s c_r;
	tsr_core_s c_nxt;

	function automatic logic [15:0] tsr_sat_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] sum;
		sum = {a[15], a} + {b[15], b};
		if (sum[16] != sum[15])
			return sum[16] ? 16'h8000 : 16'h7fff;
		return sum[15:0];
	endfunction : tsr_sat_add

	function automatic logic [14:0] tsr_period(input logic [2:0] code, input logic [1:0] sel);
		logic [14:0] base;
		logic [14:0] floor_t;
		base = tsr_pkg::CYCLE_TICKS[code];
		floor_t = tsr_pkg::AVERAGE_FLOOR_TICKS[sel];
		// No standby when averaging outlasts the cycle
		return (floor_t > base) ? floor_t : base;
	endfunction : tsr_period

	function automatic logic [2:0] tsr_nv_index(input logic [7:0] addr);
		unique case (addr)
			tsr_pkg::ADDR_CFG: return tsr_pkg::NV_CFG;
			tsr_pkg::ADDR_HI: return tsr_pkg::NV_HI;
			tsr_pkg::ADDR_LO: return tsr_pkg::NV_LO;
			tsr_pkg::ADDR_SCR1: return tsr_pkg::NV_SCR1;
			tsr_pkg::ADDR_SCR2: return tsr_pkg::NV_SCR2;
			tsr_pkg::ADDR_OFS: return tsr_pkg::NV_OFS;
			tsr_pkg::ADDR_SCR3: return tsr_pkg::NV_SCR3;
			default: return tsr_pkg::NV_NONE;
		endcase
	endfunction : tsr_nv_index

	// Loads config fields from a word; the upper mode bit is forced clear
	function automatic tsr_core_s tsr_load_cfg(input tsr_core_s s, input logic [15:0] w);
		tsr_core_s r;
		r = s;
		r.conversion_mode_field = {1'b0, w[tsr_pkg::CFG_MODE_LO]};
		r.cycle_time_code = w[tsr_pkg::CFG_CYCLE_HI:tsr_pkg::CFG_CYCLE_LO];
		r.averaging_count_select = w[tsr_pkg::CFG_AVERAGE_HI:tsr_pkg::CFG_AVERAGE_LO];
		r.thermostat_select = w[tsr_pkg::CFG_THERM];
		r.alert_output_polarity = w[tsr_pkg::CFG_POLARITY];
		r.alert_source_select = w[tsr_pkg::CFG_DRSEL];
		return r;
	endfunction : tsr_load_cfg

	function automatic tsr_core_s tsr_default();
		tsr_core_s r;
		r = '0;
		r.phase = PH_RELOAD;
		r.tmr = 20'(RELOAD_CYCLES);
		r = tsr_load_cfg(r, tsr_pkg::RST_CFG);
		r.hi_lim = tsr_pkg::RST_HI;
		r.lo_lim = tsr_pkg::RST_LO;
		r.offset = tsr_pkg::RST_OFS;
		r.temp = tsr_pkg::RST_TEMP;
		r.scr = {3{SCR_DEFAULT}};
		r.nvm = {SCR_DEFAULT, tsr_pkg::RST_OFS, SCR_DEFAULT, SCR_DEFAULT,
			tsr_pkg::RST_LO, tsr_pkg::RST_HI, tsr_pkg::RST_CFG};
		r.alert = 1'b1;
		return r;
	endfunction : tsr_default

	// Link side: one access in flight, carried by a toggle handshake
	always_comb
	begin
		l_nxt = l_r;
		l_nxt.rvalid = 1'b0;
		l_nxt.ack_s1 = c_r.ack_tgl;
		l_nxt.ack_s2 = l_r.ack_s1;
		if (!l_r.busy && (link_rd || link_wr))
		begin
			l_nxt.busy = 1'b1;
			l_nxt.wr = link_wr;
			l_nxt.addr = link_addr;
			l_nxt.wdata = link_wdata;
			l_nxt.req_tgl = ~l_r.req_tgl;
		end
		if (l_r.busy && (l_r.ack_s2 != l_r.ack_seen))
		begin
			l_nxt.ack_seen = l_r.ack_s2;
			l_nxt.busy = 1'b0;
			l_nxt.rvalid = ~l_r.wr;
			l_nxt.rdata = c_r.rdata;
		end
		if (link_gcall)
			l_nxt.gc_tgl = ~l_r.gc_tgl;
	end

	always_ff @(posedge link_clk)
	begin
		if (!link_nrst)
			l_r <= '0;
		else
			l_r <= l_nxt;
	end

	always_comb
	begin
		tsr_core_s keep;
		logic acc;
		logic do_wr;
		logic do_rd;
		logic tick_hit;
		logic [2:0] nvi;
		logic [15:0] res;
		logic [15:0] nv_val;
		logic src;
		keep = c_r;
		src = 1'b0;
		c_nxt = c_r;
		c_nxt.conv_start = 1'b0;
		c_nxt.req_s1 = l_r.req_tgl;
		c_nxt.req_s2 = c_r.req_s1;
		c_nxt.gc_s1 = l_r.gc_tgl;
		c_nxt.gc_s2 = c_r.gc_s1;
		acc = (c_r.req_s2 != c_r.req_seen);
		// Address and data stay held on the link side until the ack returns
		do_wr = acc && l_r.wr && (c_r.phase != PH_SRST);
		do_rd = acc && !l_r.wr;
		nvi = tsr_nv_index(l_r.addr);
		nv_val = l_r.wdata;
		res = tsr_sat_add(conv_data, c_r.offset);
		tick_hit = (c_r.tick == 17'(TICK_CYCLES - 1));
		c_nxt.tick = tick_hit ? 17'h0 : c_r.tick + 17'h1;
		if (c_r.tmr != 20'h0)
			c_nxt.tmr = c_r.tmr - 20'h1;
		if (acc)
		begin
			c_nxt.req_seen = c_r.req_s2;
			c_nxt.ack_tgl = ~c_r.ack_tgl;
		end

		if (do_rd)
		begin
			unique case (l_r.addr)
				tsr_pkg::ADDR_TEMP: c_nxt.rdata = c_r.temp;
				tsr_pkg::ADDR_CFG: c_nxt.rdata = {c_r.hi_flag, c_r.lo_flag, c_r.drdy,
					c_r.phase != PH_RUN, c_r.conversion_mode_field, c_r.cycle_time_code,
					c_r.averaging_count_select, c_r.thermostat_select, c_r.alert_output_polarity,
					c_r.alert_source_select, 2'b00};
				tsr_pkg::ADDR_HI: c_nxt.rdata = c_r.hi_lim;
				tsr_pkg::ADDR_LO: c_nxt.rdata = c_r.lo_lim;
				tsr_pkg::ADDR_UNL: c_nxt.rdata = {c_r.nvm_write_unlock, c_r.phase != PH_RUN,
					14'h0};
				tsr_pkg::ADDR_SCR1: c_nxt.rdata = c_r.scr[0];
				tsr_pkg::ADDR_SCR2: c_nxt.rdata = c_r.scr[1];
				tsr_pkg::ADDR_OFS: c_nxt.rdata = c_r.offset;
				tsr_pkg::ADDR_SCR3: c_nxt.rdata = c_r.scr[2];
				tsr_pkg::ADDR_ID: c_nxt.rdata = {REV_CODE, PART_CODE};
				default: c_nxt.rdata = 16'h0;
			endcase
			if (l_r.addr == tsr_pkg::ADDR_CFG)
			begin
				c_nxt.drdy = 1'b0;
				c_nxt.lo_flag = 1'b0;
				// Thermostat over flag clears only through hysteresis
				if (!c_r.thermostat_select)
					c_nxt.hi_flag = 1'b0;
			end
			if (l_r.addr == tsr_pkg::ADDR_TEMP)
				c_nxt.drdy = 1'b0;
		end

		if (do_wr)
		begin
			unique case (l_r.addr)
				tsr_pkg::ADDR_CFG:
				begin
					c_nxt = tsr_load_cfg(c_nxt, l_r.wdata);
					// Code 10 is continuous like 00 and reads back as 00
					c_nxt.conversion_mode_field =
						(l_r.wdata[tsr_pkg::CFG_MODE_HI:tsr_pkg::CFG_MODE_LO] == 2'b10) ?
						2'b00 : l_r.wdata[tsr_pkg::CFG_MODE_HI:tsr_pkg::CFG_MODE_LO];
					nv_val = l_r.wdata & tsr_pkg::CFG_NV_MASK;
					if (l_r.wdata[tsr_pkg::CFG_MODE_HI:tsr_pkg::CFG_MODE_LO] == 2'b11)
						c_nxt.conv_start = 1'b1;
				end
				tsr_pkg::ADDR_HI: c_nxt.hi_lim = l_r.wdata;
				tsr_pkg::ADDR_LO: c_nxt.lo_lim = l_r.wdata;
				tsr_pkg::ADDR_UNL: c_nxt.nvm_write_unlock = l_r.wdata[tsr_pkg::UNL_UNLOCK];
				tsr_pkg::ADDR_SCR1: c_nxt.scr[0] = l_r.wdata;
				tsr_pkg::ADDR_SCR2: c_nxt.scr[1] = l_r.wdata;
				tsr_pkg::ADDR_OFS: c_nxt.offset = l_r.wdata;
				tsr_pkg::ADDR_SCR3: c_nxt.scr[2] = l_r.wdata;
				default: c_nxt.nvm_write_unlock = c_nxt.nvm_write_unlock;
			endcase
			// Locked writes stop at the logic register
			if (c_r.nvm_write_unlock && (nvi != tsr_pkg::NV_NONE) &&
				(c_r.phase == PH_RUN))
			begin
				c_nxt.nvm[nvi] = nv_val;
				c_nxt.phase = PH_PROG;
				c_nxt.tmr = 20'(PROG_CYCLES);
			end
		end

		if (conv_done && (c_r.phase != PH_SRST) && (c_r.phase != PH_RELOAD))
		begin
			c_nxt.temp = res;
			// Set after the read clear so a coincident event wins
			c_nxt.drdy = 1'b1;
			if (c_r.thermostat_select)
			begin
				if ($signed(res) > $signed(c_r.hi_lim))
					c_nxt.hi_flag = 1'b1;
				else if ($signed(res) < $signed(c_r.lo_lim))
					c_nxt.hi_flag = 1'b0;
				c_nxt.lo_flag = 1'b0;
			end
			else
			begin
				if ($signed(res) > $signed(c_r.hi_lim))
					c_nxt.hi_flag = 1'b1;
				if ($signed(res) < $signed(c_r.lo_lim))
					c_nxt.lo_flag = 1'b1;
			end
			if (c_r.conversion_mode_field == 2'b11)
				c_nxt.conversion_mode_field = 2'b01;
		end

		// Conversion scheduling in continuous mode
		if ((c_r.phase == PH_RUN) || (c_r.phase == PH_PROG))
		begin
			if (c_r.conversion_mode_field[0])
				c_nxt.cyc = 15'h0;
			else if (tick_hit)
			begin
				if (c_r.cyc >= tsr_period(c_r.cycle_time_code, c_r.averaging_count_select) -
					15'h1)
				begin
					c_nxt.cyc = 15'h0;
					c_nxt.conv_start = 1'b1;
				end
				else
					c_nxt.cyc = c_r.cyc + 15'h1;
			end
		end

		unique case (c_r.phase)
			PH_RELOAD:
				if (c_r.tmr == 20'h0)
				begin
					c_nxt = tsr_load_cfg(c_nxt, c_r.nvm[tsr_pkg::NV_CFG]);
					c_nxt.hi_lim = c_r.nvm[tsr_pkg::NV_HI];
					c_nxt.lo_lim = c_r.nvm[tsr_pkg::NV_LO];
					c_nxt.scr[0] = c_r.nvm[tsr_pkg::NV_SCR1];
					c_nxt.scr[1] = c_r.nvm[tsr_pkg::NV_SCR2];
					c_nxt.scr[2] = c_r.nvm[tsr_pkg::NV_SCR3];
					c_nxt.offset = c_r.nvm[tsr_pkg::NV_OFS];
					c_nxt.phase = PH_RUN;
					c_nxt.cyc = 15'h0;
					c_nxt.conv_start = ~c_r.nvm[tsr_pkg::NV_CFG][tsr_pkg::CFG_MODE_LO];
				end
			PH_SRST:
				if (c_r.tmr == 20'h0)
				begin
					c_nxt.phase = PH_RELOAD;
					c_nxt.tmr = 20'(RELOAD_CYCLES);
				end
			PH_PROG:
				if (c_r.tmr == 20'h0)
					c_nxt.phase = PH_RUN;
			PH_RUN:
				c_nxt.phase = c_nxt.phase;
		endcase

		// Soft reset or general call: registers to defaults, cells and crossings kept
		if ((do_wr && (l_r.addr == tsr_pkg::ADDR_CFG) && l_r.wdata[tsr_pkg::CFG_SRST]) ||
			(c_r.gc_s2 != c_r.gc_seen))
		begin
			keep = c_nxt;
			c_nxt = tsr_default();
			c_nxt.phase = PH_SRST;
			c_nxt.tmr = 20'(SRST_CYCLES);
			c_nxt.nvm = keep.nvm;
			c_nxt.req_s1 = keep.req_s1;
			c_nxt.req_s2 = keep.req_s2;
			c_nxt.req_seen = keep.req_seen;
			c_nxt.gc_s1 = keep.gc_s1;
			c_nxt.gc_s2 = keep.gc_s2;
			c_nxt.gc_seen = c_r.gc_s2;
			c_nxt.ack_tgl = keep.ack_tgl;
			c_nxt.rdata = keep.rdata;
			c_nxt.tick = keep.tick;
		end

		src = c_nxt.alert_source_select ? c_nxt.drdy : (c_nxt.hi_flag | c_nxt.lo_flag);
		c_nxt.alert = c_nxt.alert_output_polarity ? src : ~src;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			c_r <= tsr_default();
		else
			c_r <= c_nxt;
	end

	assign link_ready = ~l_r.busy;
	assign link_rvalid = l_r.rvalid;
	assign link_rdata = l_r.rdata;
	assign conv_start = c_r.conv_start;
	assign averaging_count_select = c_r.averaging_count_select;
	assign nvm_busy = (c_r.phase != PH_RUN);
	assign alert_out = c_r.alert;
endmodule : tsr_regfile

// ---- verif/tsr_regfile_props.sv ----
// Port assertions for the sensor register file
`timescale 1ns/100ps
module tsr_regfile_props #(
	parameter logic [3:0] REV_CODE = 4'h0,
	parameter logic [11:0] PART_CODE = 12'h5a3
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic link_nrst,
	input wire logic link_rd,
	input wire logic link_wr,
	input wire logic [7:0] link_addr,
	input wire logic link_ready,
	input wire logic link_rvalid,
	input wire logic [15:0] link_rdata,
	input wire logic conv_start,
	input wire logic nvm_busy,
	input wire logic alert_out
);
	// Pointer of the read in flight, so each answer is judged by register
	logic [7:0] rd_addr_r;
	logic [7:0] rd_addr_nxt;
	always_comb
	begin
		rd_addr_nxt = rd_addr_r;
		if (link_ready && link_rd && !link_wr)
			rd_addr_nxt = link_addr;
	end
	always_ff @(posedge link_clk)
	begin
		if (!link_nrst)
			rd_addr_r <= 8'h00;
		else
			rd_addr_r <= rd_addr_nxt;
	end
	sequence take_s;
		(link_rd || link_wr) && link_ready;
	endsequence
	sequence trip_s;
		!link_ready ##[2:40] link_ready;
	endsequence
	sequence reload_s;
		nvm_busy ##[1:40] !nvm_busy;
	endsequence
	property answer_p(a, m, v);
		@(posedge link_clk) disable iff (!link_nrst)
		link_rvalid && rd_addr_r == a |-> (link_rdata & m) == v;
	endproperty
	req_trip_a: assert property (@(posedge link_clk) disable iff (!link_nrst)
		take_s |=> trip_s) else $error("link request not answered in time");
	rvalid_pulse_a: assert property (@(posedge link_clk) disable iff (!link_nrst)
		link_rvalid |-> link_ready ##1 !link_rvalid) else $error("read valid not one pulse");
	cfg_unused_a: assert property (answer_p(tsr_pkg::ADDR_CFG, 16'h0003, 16'h0000))
		else $error("config low bits not zero");
	unl_unused_a: assert property (answer_p(tsr_pkg::ADDR_UNL, 16'h3fff, 16'h0000))
		else $error("unlock unused bits not zero");
	id_word_a: assert property (answer_p(tsr_pkg::ADDR_ID, 16'hffff, {REV_CODE, PART_CODE}))
		else $error("identity word wrong");
	reload_busy_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(nrst) |-> reload_s) else $error("reload busy missing or too long");
	reset_alert_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(nrst) |-> alert_out && !conv_start) else $error("alert active after reset");
	start_pulse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		conv_start |=> !conv_start) else $error("start not a single pulse");
endmodule : tsr_regfile_props

// ---- verif/tsr_link_host.sv ----
// Host model driving register reads and writes on the link port
`timescale 1ns/100ps
module tsr_link_host (
	input wire logic link_clk,
	output logic link_rd,
	output logic link_wr,
	output logic [7:0] link_addr,
	output logic [15:0] link_wdata,
	output logic link_gcall,
	input wire logic link_ready,
	input wire logic [15:0] link_rdata
);
	logic unlocked = 1'b0;
	initial
	begin
		link_rd = 1'b0;
		link_wr = 1'b0;
		link_addr = 8'h00;
		link_wdata = 16'h0000;
		link_gcall = 1'b0;
	end
	// Request held until the edge that takes it; bus then scrambled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge link_clk);
		link_wr <= w;
		link_rd <= !w;
		link_addr <= a;
		link_wdata <= d;
		do
			@(posedge link_clk);
		while (link_ready !== 1'b1);
		link_wr <= 1'b0;
		link_rd <= 1'b0;
		link_addr <= ~a;
		link_wdata <= ~d;
		do
			@(posedge link_clk);
		while (link_ready !== 1'b1);
		q = link_rdata;
	endtask : xfer
	task automatic write_word(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		// Traceability word is never reprogrammed
		if (a == tsr_pkg::ADDR_SCR1 && unlocked)
			return;
		if (a == tsr_pkg::ADDR_UNL)
			unlocked = d[15];
		xfer(1'b1, a, d, q);
	endtask : write_word
	task automatic read_word(input logic [7:0] a, output logic [15:0] q);
		xfer(1'b0, a, ~link_rdata, q);
	endtask : read_word
	task automatic gcall;
		@(posedge link_clk);
		link_gcall <= 1'b1;
		@(posedge link_clk);
		link_gcall <= 1'b0;
	endtask : gcall
endmodule : tsr_link_host

// ---- verif/tsr_regfile_tb.sv ----
// Self-checking bench for the sensor register file
`timescale 1ns/100ps
module tsr_regfile_tb;
	localparam int SRST = 50;
	// Arbitrary identity values
	localparam logic [3:0] REV = 4'h3;
	localparam logic [11:0] PART = 12'h2c9;
	logic ref_clk, link_clk, nrst, link_nrst, link_rd, link_wr, link_gcall;
	logic link_ready, link_rvalid, conv_done, conv_start, nvm_busy, alert_out;
	logic [7:0] link_addr;
	logic [15:0] link_wdata, link_rdata, conv_data, v, q;
	logic [1:0] averaging_count_select;
	logic [31:0] seed;
	logic [49:0] r;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;
	logic [23:0] rst_tab[11] = '{24'h008000, 24'h010220, 24'h026000, 24'h038000, 24'h040000,
		24'h050000, 24'h060000, 24'h070000, 24'h080000, 24'h090000, {8'h0f, REV, PART}};
	logic [7:0] rw_tab[6] = '{8'h02, 8'h03, 8'h07, 8'h05, 8'h06, 8'h08};
	logic [49:0] cv_tab[6] = '{{16'h0400, 16'h7000, 16'h7000, 2'b00},
		{16'h0408, 16'h9000, 16'h9000, 2'b11}, {16'h040c, 16'h0010, 16'h0c00, 2'b10},
		{16'h0410, 16'h0000, 16'h2000, 2'b00}, {16'h0410, 16'h0000, 16'h0c00, 2'b00},
		{16'h0410, 16'h0000, 16'h0400, 2'b11}};
	tsr_regfile #(.SRST_CYCLES(SRST), .TICK_CYCLES(10), .RELOAD_CYCLES(4), .PROG_CYCLES(64),
		.REV_CODE(REV), .PART_CODE(PART)) dut (.ref_clk(ref_clk), .nrst(nrst),
		.link_clk(link_clk), .link_nrst(link_nrst), .link_rd(link_rd), .link_wr(link_wr),
		.link_addr(link_addr), .link_wdata(link_wdata), .link_ready(link_ready),
		.link_rvalid(link_rvalid), .link_rdata(link_rdata), .link_gcall(link_gcall),
		.conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
		.averaging_count_select(averaging_count_select), .nvm_busy(nvm_busy),
		.alert_out(alert_out));
	tsr_link_host u_host (.link_clk(link_clk), .link_rd(link_rd), .link_wr(link_wr),
		.link_addr(link_addr), .link_wdata(link_wdata), .link_gcall(link_gcall),
		.link_ready(link_ready), .link_rdata(link_rdata));
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			failures++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		u_host.read_word(a, d);
		chk($sformatf("reg %h", a), exp, d);
	endtask : rc
	task automatic wait_idle(output int k);
		k = 0;
		while (nvm_busy !== 1'b0 && k < 5000)
		begin
			@(posedge ref_clk);
			k++;
		end
	endtask : wait_idle
	function automatic logic [15:0] sat(input logic [15:0] t, input logic [15:0] o);
		logic [16:0] s;
		s = {t[15], t} + {o[15], o};
		return (s[16] != s[15]) ? (s[16] ? 16'h8000 : 16'h7fff) : s[15:0];
	endfunction : sat
	task automatic conv_chk(input logic [15:0] o, input logic [15:0] d, input logic [1:0] al);
		u_host.write_word(tsr_pkg::ADDR_OFS, o);
		u_host.read_word(tsr_pkg::ADDR_CFG, q);
		@(posedge ref_clk);
		conv_done <= 1'b1;
		conv_data <= d;
		@(posedge ref_clk);
		conv_done <= 1'b0;
		conv_data <= ~d;
		#1;
		chk("alert on result", {15'h0, al[1]}, {15'h0, alert_out});
		rc(tsr_pkg::ADDR_TEMP, sat(d, o));
		chk("alert after read", {15'h0, al[0]}, {15'h0, alert_out});
	endtask : conv_chk
	task automatic period(input logic [2:0] c, input logic [1:0] a, input int t);
		u_host.write_word(tsr_pkg::ADDR_CFG, {6'h00, c, a, 5'h00});
		chk("averaging select", {14'h0, a}, {14'h0, averaging_count_select});
		n = 0;
		while (conv_start !== 1'b1 && n < 40000)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		n = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		while (conv_start !== 1'b1 && n < 40000);
		chk("cycle length", 16'h1, 16'(n >= t * 10 - 1 && n <= t * 10 + 1));
	endtask : period
	initial
	begin
		seed = 32'h52f61408;
		nrst = 1'b0;
		link_nrst = 1'b0;
		conv_done = 1'b0;
		conv_data = 16'h0000;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		link_nrst <= 1'b1;
		wait_idle(n);
		chk("alert idle", 16'h1, {15'h0, alert_out});
		foreach (rst_tab[i])
			rc(rst_tab[i][23:16], rst_tab[i][15:0]);
		$display("test reset values done");
		for (int i = 0; i < 12; i++)
		begin
			v = 16'($random(seed));
			u_host.write_word(rw_tab[i % 6], v);
			rc(rw_tab[i % 6], v);
		end
		u_host.write_word(tsr_pkg::ADDR_ID, 16'hffff);
		rc(tsr_pkg::ADDR_ID, {REV, PART});
		u_host.write_word(tsr_pkg::ADDR_UNL, 16'h3fff);
		rc(tsr_pkg::ADDR_UNL, 16'h0000);
		v = (16'($random(seed)) & 16'hf3fd) | 16'h0801;
		u_host.write_word(tsr_pkg::ADDR_CFG, v);
		rc(tsr_pkg::ADDR_CFG, v & 16'h03fc);
		chk("alert level", {15'h0, ~v[3]}, {15'h0, alert_out});
		$display("test locked writes done");
		u_host.write_word(tsr_pkg::ADDR_CFG, 16'h0002);
		chk("soft reset busy", 16'h1, {15'h0, nvm_busy});
		wait_idle(n);
		chk("soft reset length", 16'h1, 16'(n >= SRST - 10 && n <= SRST + 20));
		rc(tsr_pkg::ADDR_CFG, 16'h0220);
		rc(tsr_pkg::ADDR_HI, 16'h6000);
		$display("test soft reset done");
		u_host.write_word(tsr_pkg::ADDR_UNL, 16'h8000);
		rc(tsr_pkg::ADDR_UNL, 16'h8000);
		v = 16'($random(seed));
		u_host.write_word(tsr_pkg::ADDR_HI, v);
		rc(tsr_pkg::ADDR_UNL, 16'hc000);
		wait_idle(n);
		u_host.write_word(tsr_pkg::ADDR_SCR2, ~v);
		wait_idle(n);
		u_host.write_word(tsr_pkg::ADDR_SCR3, v ^ 16'h00ff);
		wait_idle(n);
		u_host.write_word(tsr_pkg::ADDR_CFG, 16'h0c9c);
		wait_idle(n);
		u_host.write_word(tsr_pkg::ADDR_SCR1, 16'hbeef);
		u_host.write_word(tsr_pkg::ADDR_UNL, 16'h0000);
		u_host.write_word(tsr_pkg::ADDR_HI, 16'h0101);
		u_host.gcall();
		repeat (20) @(posedge ref_clk);
		wait_idle(n);
		rc(tsr_pkg::ADDR_HI, v);
		rc(tsr_pkg::ADDR_SCR2, ~v);
		rc(tsr_pkg::ADDR_SCR3, v ^ 16'h00ff);
		rc(tsr_pkg::ADDR_SCR1, 16'h0000);
		rc(tsr_pkg::ADDR_CFG, 16'h049c);
		$display("test programming done");
		u_host.write_word(tsr_pkg::ADDR_HI, 16'h1000);
		u_host.write_word(tsr_pkg::ADDR_LO, 16'h0800);
		foreach (cv_tab[i])
		begin
			r = cv_tab[i];
			u_host.write_word(tsr_pkg::ADDR_CFG, r[49:34]);
			conv_chk(r[33:18], r[17:2], r[1:0]);
		end
		u_host.write_word(tsr_pkg::ADDR_CFG, 16'h0404);
		for (int i = 0; i < 8; i++)
		begin
			v = 16'($random(seed));
			conv_chk(v, 16'($random(seed)), 2'b01);
		end
		$display("test conversions done");
		period(3'h0, 2'h0, 31);
		period(3'h0, 2'h1, 250);
		period(3'h2, 2'h2, 1000);
		period(3'h4, 2'h3, 2000);
		$display("test cycle times done");
		tally_and_finish();
	end
endmodule : tsr_regfile_tb
bind tsr_regfile tsr_regfile_props #(.REV_CODE(REV_CODE), .PART_CODE(PART_CODE)) u_props (
	.ref_clk(ref_clk), .nrst(nrst), .link_clk(link_clk), .link_nrst(link_nrst),
	.link_rd(link_rd), .link_wr(link_wr), .link_addr(link_addr), .link_ready(link_ready),
	.link_rvalid(link_rvalid), .link_rdata(link_rdata), .conv_start(conv_start),
	.nvm_busy(nvm_busy), .alert_out(alert_out));
